// file: hw/nand_cycle_gen.sv
// one command, address, data-in or data-out cycle on the flash pins
// assumes start is a one-cycle pulse given only while idle is high
`timescale 1ns/100ps
`default_nettype none
module nand_cycle_gen
	import nand_host_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        start,
	input  wire cycle_t      kind,
	input  wire logic [15:0] dout,
	input  wire logic [15:0] io_in,
	output logic             idle,
	output logic             done,
	output logic [15:0]      rdata,
	output pins_t            pins
);
	typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_HIGH} phase_t;
	typedef struct packed {
		phase_t      phase;
		logic [3:0]  cnt;
		logic        rd;
		logic        done;
		logic [15:0] rdata;
		logic [15:0] io_s1;
		logic [15:0] io_s2;
		pins_t       pins;
	} gen_t;

	gen_t st_r;
	gen_t st_nxt;

	////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		st_nxt.io_s1 = io_in;
		st_nxt.io_s2 = st_r.io_s1;
		unique case (st_r.phase)
			PH_IDLE: begin
				if (start) begin
					st_nxt.rd = (kind == CY_RDATA);
					st_nxt.pins.cle = (kind == CY_CMD);
					st_nxt.pins.ale = (kind == CY_ADDR);
					st_nxt.pins.io_out = dout;
					st_nxt.pins.io_oe = (kind != CY_RDATA);
					st_nxt.pins.we_n = (kind == CY_RDATA);
					st_nxt.pins.output_strobe_n = (kind != CY_RDATA);
					// reads stay low longer to cover the input synchroniser
					st_nxt.cnt = (kind == CY_RDATA) ? 4'(READ_LOW_CYC - 1) : 4'(STROBE_LOW_CYC - 1);
					st_nxt.phase = PH_LOW;
				end
			end
			PH_LOW: begin
				if (st_r.cnt == 4'h0) begin
					st_nxt.pins.we_n = 1'b1;
					st_nxt.pins.output_strobe_n = 1'b1;
					if (st_r.rd) begin
						st_nxt.rdata = st_r.io_s2;
					end
					st_nxt.cnt = 4'(STROBE_HIGH_CYC - 1);
					st_nxt.phase = PH_HIGH;
				end else begin
					st_nxt.cnt = st_r.cnt - 4'h1;
				end
			end
			PH_HIGH: begin
				if (st_r.cnt == 4'h0) begin
					// data and latches held through the high phase for hold time
					st_nxt.pins.io_oe = 1'b0;
					st_nxt.pins.cle = 1'b0;
					st_nxt.pins.ale = 1'b0;
					st_nxt.done = 1'b1;
					st_nxt.phase = PH_IDLE;
				end else begin
					st_nxt.cnt = st_r.cnt - 4'h1;
				end
			end
			default: st_nxt.phase = PH_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_r <= '0;
			st_r.pins.we_n <= 1'b1;
			st_r.pins.output_strobe_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign idle  = (st_r.phase == PH_IDLE);
	assign done  = st_r.done;
	assign rdata = st_r.rdata;
	assign pins  = st_r.pins;

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence write_pulse_s;
		(!st_r.pins.we_n)[*3] ##1 st_r.pins.we_n;
	endsequence
	sequence cmd_latch_s;
		st_r.pins.cle && st_r.pins.io_oe;
	endsequence

	a_write_pulse_len: assert property ($fell(st_r.pins.we_n) |-> write_pulse_s)
		else $error("write strobe low time wrong");
	a_cmd_latched: assert property (start && idle && kind == CY_CMD |=> cmd_latch_s ##0
		(!st_r.pins.we_n)[*3])
		else $error("command cycle not driven");
endmodule
`default_nettype wire

// file: hw/nand_host.sv
// host controller for an asynchronous nand flash, steered over apb
// assumes the flash pins attach directly; ready line has an external pull-up
`timescale 1ns/100ps
`default_nettype none
module nand_host
	import nand_host_pkg::*;
#(
	parameter int POWERUP_CYCLES = POWERUP_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             ce_n,
	output logic             cle,
	output logic             ale,
	output logic             we_n,
	output logic             output_strobe_n,
	output logic             wp_n,
	output logic [15:0]      io_out,
	output logic             io_oe,
	input  wire logic [15:0] io_in,
	input  wire logic        rb_n
);
	typedef enum logic [1:0] {SQ_IDLE, SQ_CYCLE, SQ_SETTLE, SQ_WAIT_RB} seq_t;
	typedef enum logic [1:0] {MD_NONE, MD_PROG, MD_ERASE, MD_STATUS} mode_t;
	typedef struct packed {
		seq_t             seq;
		mode_t            mode;
		logic [CNT_W-1:0] pwr_cnt;
		logic             pwr_done;
		logic             rb_s1;
		logic             rb_s2;
		logic             wp_rel;
		logic             ce_en;
		logic             wide;
		logic [15:0]      wdata;
		logic [15:0]      rdata;
		logic [7:0]       stat_byte;
		logic             fail;
		logic             refused;
		logic             start;
		cycle_t           kind;
		logic [15:0]      dout;
		logic [3:0]       cnt;
		logic             ce_n;
		logic             wp_n;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
	} host_t;

	host_t       st_r;
	host_t       st_nxt;
	logic        gen_idle;
	logic        gen_done;
	logic [15:0] gen_rdata;
	pins_t       gen_pins;
	logic        acc_wr;
	logic        cmd_req;
	logic        cap_ok;
	logic [7:0]  code;
	op_t         op;

	assign acc_wr  = psel && penable && pwrite && st_r.pready;
	assign code    = pwdata[CTRL_CODE_LSB +: 8];
	assign op      = op_t'(pwdata[CTRL_OP_LSB +: 3]);
	assign cmd_req = acc_wr && paddr == OFS_CTRL && st_r.seq == SQ_IDLE && st_r.pwr_done
		&& op == OP_CMD;
	assign cap_ok  = gen_done && st_r.kind == CY_RDATA && st_r.mode == MD_STATUS
		&& gen_rdata[SB_READY];

	////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.start = 1'b0;
		st_nxt.rb_s1 = rb_n;
		st_nxt.rb_s2 = st_r.rb_s1;
		if (!st_r.pwr_done) begin
			if (st_r.pwr_cnt == CNT_W'(POWERUP_CYCLES - 1)) begin
				st_nxt.pwr_done = 1'b1;
			end else begin
				st_nxt.pwr_cnt = st_r.pwr_cnt + 1'b1;
			end
		end
		// select and write guard stay parked until the power-up wait ends
		st_nxt.ce_n = !(st_r.pwr_done && st_r.ce_en);
		st_nxt.wp_n = st_r.pwr_done && st_r.wp_rel;

		// apb: answer prepared in setup, pready high in the access cycle
		st_nxt.pready = psel && !penable;
		st_nxt.pslverr = 1'b0;
		st_nxt.prdata = '0;
		if (psel && !penable) begin
			unique case (paddr)
				OFS_CTRL: st_nxt.prdata = '0;
				OFS_WDATA: st_nxt.prdata = {16'h0000, st_r.wdata};
				OFS_RDATA: st_nxt.prdata = {16'h0000, st_r.rdata};
				OFS_STATUS: begin
					st_nxt.prdata[ST_ACTIVE] = (st_r.seq != SQ_IDLE);
					st_nxt.prdata[ST_READY] = st_r.rb_s2;
					st_nxt.prdata[ST_REFUSED] = st_r.refused;
					st_nxt.prdata[ST_FAIL] = st_r.fail;
					st_nxt.prdata[ST_POWERED] = st_r.pwr_done;
					st_nxt.prdata[ST_STATMODE] = (st_r.mode == MD_STATUS);
					st_nxt.prdata[ST_BYTE_LSB +: 8] = st_r.stat_byte;
				end
				OFS_CONFIG: begin
					st_nxt.prdata[CFG_WP_REL] = st_r.wp_rel;
					st_nxt.prdata[CFG_CE_EN] = st_r.ce_en;
					st_nxt.prdata[CFG_WIDE] = st_r.wide;
				end
				default: st_nxt.pslverr = 1'b1;
			endcase
		end
		if (acc_wr && paddr == OFS_WDATA) begin
			st_nxt.wdata = pwdata[15:0];
		end
		if (acc_wr && paddr == OFS_CONFIG) begin
			st_nxt.wp_rel = pwdata[CFG_WP_REL];
			st_nxt.ce_en = pwdata[CFG_CE_EN];
			st_nxt.wide = pwdata[CFG_WIDE];
		end
		if (acc_wr && paddr == OFS_STATUS && pwdata[ST_REFUSED]) begin
			st_nxt.refused = 1'b0;
		end

		unique case (st_r.seq)
			SQ_IDLE: begin
				if (acc_wr && paddr == OFS_CTRL) begin
					st_nxt.dout = {8'h00, code};
					st_nxt.refused = 1'b1;
					if (st_r.pwr_done && gen_idle) begin
						unique case (op)
							OP_CMD: begin
								if (is_defined_cmd(code)
									&& (st_r.rb_s2 || busy_allowed(code))
									&& (st_r.mode != MD_PROG || code == CMD_PROG_GO
									|| code == CMD_RESET)) begin
									st_nxt.refused = st_r.refused;
									st_nxt.kind = CY_CMD;
									st_nxt.start = 1'b1;
									st_nxt.seq = SQ_CYCLE;
									if (code == CMD_PROG_SET) begin
										st_nxt.mode = MD_PROG;
									end else if (code == CMD_ERASE) begin
										st_nxt.mode = MD_ERASE;
									end else if (code == CMD_STATUS) begin
										st_nxt.mode = MD_STATUS;
									end else if (code == CMD_READ_A || code == CMD_RESET) begin
										st_nxt.mode = MD_NONE;
									end else if (st_r.mode != MD_STATUS) begin
										st_nxt.mode = MD_NONE;
									end
								end
							end
							OP_ADDR, OP_WDATA, OP_RDATA: begin
								st_nxt.refused = st_r.refused;
								st_nxt.kind = (op == OP_ADDR) ? CY_ADDR
									: (op == OP_WDATA) ? CY_WDATA : CY_RDATA;
								if (op == OP_WDATA) begin
									st_nxt.dout = st_r.wide ? st_r.wdata : {8'h00, st_r.wdata[7:0]};
								end
								st_nxt.start = 1'b1;
								st_nxt.seq = SQ_CYCLE;
							end
							OP_WAIT: begin
								st_nxt.refused = st_r.refused;
								st_nxt.cnt = 4'(BUSY_SETTLE_CYC - 1);
								st_nxt.seq = SQ_SETTLE;
							end
							default: st_nxt.refused = 1'b1;
						endcase
					end
				end
			end
			SQ_CYCLE: begin
				if (gen_done) begin
					st_nxt.seq = SQ_IDLE;
					if (st_r.kind == CY_RDATA) begin
						st_nxt.rdata = st_r.wide ? gen_rdata : {8'h00, gen_rdata[7:0]};
						if (st_r.mode == MD_STATUS) begin
							st_nxt.stat_byte = gen_rdata[7:0];
						end
					end
					if (cap_ok) begin
						st_nxt.fail = gen_rdata[SB_FAIL];
					end
				end
			end
			SQ_SETTLE: begin
				// ready line needs time to fall after the strobe edge
				if (st_r.cnt == 4'h0) begin
					st_nxt.seq = SQ_WAIT_RB;
				end else begin
					st_nxt.cnt = st_r.cnt - 4'h1;
				end
			end
			SQ_WAIT_RB: begin
				if (st_r.rb_s2) begin
					st_nxt.seq = SQ_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_r <= '0;
			st_r.ce_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	nand_cycle_gen u_gen (
		.sys_clk (sys_clk),
		.srst    (srst),
		.start   (st_r.start),
		.kind    (st_r.kind),
		.dout    (st_r.dout),
		.io_in   (io_in),
		.idle    (gen_idle),
		.done    (gen_done),
		.rdata   (gen_rdata),
		.pins    (gen_pins)
	);

	assign prdata  = st_r.prdata;
	assign pready  = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign ce_n    = st_r.ce_n;
	assign wp_n    = st_r.wp_n;
	assign cle     = gen_pins.cle;
	assign ale     = gen_pins.ale;
	assign we_n    = gen_pins.we_n;
	assign output_strobe_n = gen_pins.output_strobe_n;
	assign io_out  = gen_pins.io_out;
	assign io_oe   = gen_pins.io_oe;

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_wp_power_hold: assert property (!st_r.pwr_done |=> !wp_n)
		else $error("write guard released before power-up wait");
	a_ce_power_hold: assert property (!st_r.pwr_done |=> ce_n)
		else $error("chip select active before power-up wait");
	a_power_wait_len: assert property ($rose(st_r.pwr_done) |->
		$past(st_r.pwr_cnt) == CNT_W'(POWERUP_CYCLES - 1))
		else $error("power-up wait length wrong");
	a_busy_cmd_block: assert property (cmd_req && !st_r.rb_s2 && !busy_allowed(code)
		|=> st_r.refused && !st_r.start)
		else $error("command issued while busy");
	a_prog_follow_guard: assert property (cmd_req && st_r.mode == MD_PROG
		&& code != CMD_PROG_GO && code != CMD_RESET |=> !st_r.start ##1 !st_r.start)
		else $error("illegal command after program setup");
	a_undef_cmd_block: assert property (cmd_req && !is_defined_cmd(code)
		|=> st_r.refused && st_r.seq == SQ_IDLE)
		else $error("undefined command issued");
	a_fail_from_ready: assert property ($changed(st_r.fail) |-> $past(cap_ok))
		else $error("fail bit taken while busy");
	a_wait_ready_end: assert property (st_r.seq == SQ_WAIT_RB && st_r.rb_s2
		|=> st_r.seq == SQ_IDLE)
		else $error("ready not honoured");
endmodule
`default_nettype wire

// file: hw/nand_host_pkg.sv
// constants, types and helpers for the nand flash host controller
// assumes one 100 MHz clock and a byte-addressed apb register window
// Summary of operation
// - fail bit trusted only when ready shown
// - host issues only defined command codes
// - while busy only 70h or ffh sent
// - after 80h only 10h or ffh follow
// - chip select high, write guard low at power-up
// - wait about 200 us before first access
// - shared ready line resolved by status reads
package nand_host_pkg;
	localparam int CLK_MHZ          = 100;
	localparam int CLK_PERIOD_NS    = 10;
	localparam int T_STROBE_LOW_NS  = 30;
	localparam int T_STROBE_HIGH_NS = 20;
	localparam int T_BUSY_SETTLE_NS = 100;
	localparam int T_POWERUP_US     = 200;
	localparam int STROBE_LOW_CYC   = (T_STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_HIGH_CYC  = (T_STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_SETTLE_CYC  = (T_BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POWERUP_CYC      = T_POWERUP_US * CLK_MHZ;
	localparam int SYNC_STAGES      = 2;
	localparam int READ_LOW_CYC     = STROBE_LOW_CYC + SYNC_STAGES;
	localparam int CNT_W            = 16;

	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_WDATA  = 8'h04;
	localparam logic [7:0] OFS_RDATA  = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_CONFIG = 8'h10;

	localparam int CTRL_OP_LSB   = 0;
	localparam int CTRL_CODE_LSB = 8;
	localparam int ST_ACTIVE     = 0;
	localparam int ST_READY      = 1;
	localparam int ST_REFUSED    = 2;
	localparam int ST_FAIL       = 3;
	localparam int ST_POWERED    = 4;
	localparam int ST_STATMODE   = 5;
	localparam int ST_BYTE_LSB   = 8;
	localparam int CFG_WP_REL    = 0;
	localparam int CFG_CE_EN     = 1;
	localparam int CFG_WIDE      = 2;
	localparam int SB_FAIL       = 0;
	localparam int SB_READY      = 6;

	localparam logic [7:0] CMD_READ_A   = 8'h00;
	localparam logic [7:0] CMD_READ_B   = 8'h01;
	localparam logic [7:0] CMD_READ_C   = 8'h50;
	localparam logic [7:0] CMD_PROG_SET = 8'h80;
	localparam logic [7:0] CMD_PROG_GO  = 8'h10;
	localparam logic [7:0] CMD_ERASE    = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
	localparam logic [7:0] CMD_STATUS   = 8'h70;
	localparam logic [7:0] CMD_ID       = 8'h90;
	localparam logic [7:0] CMD_RESET    = 8'hff;

	typedef enum logic [2:0] {OP_CMD, OP_ADDR, OP_WDATA, OP_RDATA, OP_WAIT} op_t;
	typedef enum logic [1:0] {CY_CMD, CY_ADDR, CY_WDATA, CY_RDATA} cycle_t;

	typedef struct packed {
		logic        cle;
		logic        ale;
		logic        we_n;
		logic        output_strobe_n;
		logic        io_oe;
		logic [15:0] io_out;
	} pins_t;

	function automatic logic is_defined_cmd(input logic [7:0] c);
		return c inside {CMD_READ_A, CMD_READ_B, CMD_READ_C, CMD_PROG_SET, CMD_PROG_GO,
			CMD_ERASE, CMD_ERASE_GO, CMD_STATUS, CMD_ID, CMD_RESET};
	endfunction

	function automatic logic busy_allowed(input logic [7:0] c);
		return c == CMD_STATUS || c == CMD_RESET;
	endfunction
endpackage

// file: test/nand_flash_model.sv
// behavioural flash device facing the host controller pins
// assumes host pins are registered on sys_clk; the bench resolves io and the ready pull-up
`timescale 1ns/100ps
`default_nettype none
module nand_flash_model #(
	parameter logic [7:0] MAKER_ID  = 8'h3c, // arbitrary value
	parameter logic [7:0] DEVICE_ID = 8'hc3, // arbitrary value
	parameter int         BUSY_CYC  = 30
) (
	input  wire logic        sys_clk,
	input  wire logic        ce_n,
	input  wire logic        cle,
	input  wire logic        ale,
	input  wire logic        we_n,
	input  wire logic        output_strobe_n,
	input  wire logic        wp_n,
	input  wire logic [15:0] io_bus,
	output logic [15:0]      io_drive,
	output logic             rb_low
);
	logic [7:0] mem [0:527];
	logic [7:0] pbuf [0:527];
	logic [9:0] ptr, base;
	logic [7:0] last_cmd, dq;
	logic [1:0] mode, acnt, pend;
	logic       we_q, ostb_q, id_dev, fail_q;
	int         busy;
	// released lines show the inverse, not a stale copy
	assign io_drive = (!ce_n && !output_strobe_n) ? {8'h00, dq} : ~{8'h00, dq};
	initial begin
		for (int i = 0; i < 528; i++)
			mem[i] = i[7:0] ^ 8'h5a;
		{ptr, base, last_cmd, dq, mode, acnt, pend, id_dev} = '0;
		{we_q, ostb_q} = 2'b11;
		busy = 0;
		fail_q = 1'b0;
		rb_low = 1'b0;
	end
	always @(posedge sys_clk) begin
		we_q <= we_n;
		ostb_q <= output_strobe_n;
		if (!wp_n && pend[1]) begin
			busy = 0;
			pend = 0;
		end
		if (busy > 0) begin
			busy = busy - 1;
			for (int i = 0; i < 528; i++)
				if (busy == 0)
					mem[i] = (pend == 3) ? 8'hff : (pend == 2) ? mem[i] & pbuf[i] : mem[i];
			// finished job no longer pending, so a later busy spell leaves memory alone
			if (busy == 0)
				pend = 0;
		end
		if (!ce_n && we_n && !we_q) begin
			if (cle) begin
				case (io_bus[7:0])
				8'h00: begin
					base = 0;
					mode = 0;
				end
				8'h01: base = 256;
				8'h50: base = 512;
				8'h70: mode = 1;
				8'h90: begin
					mode = 2;
					id_dev = 0;
				end
				8'h80: for (int i = 0; i < 528; i++)
					pbuf[i] = 8'hff;
				8'h10: if (last_cmd == 8'h80 && wp_n) begin
					busy = BUSY_CYC;
					pend = 2;
					fail_q = 1'b0;
				end
				8'hd0: if (last_cmd == 8'h60 && wp_n) begin
					busy = 2 * BUSY_CYC;
					pend = 3;
					fail_q = 1'b0;
				end
				8'hff: begin
					// an aborted program or erase is reported as failed
					if (busy > 0 && pend[1])
						fail_q = 1'b1;
					busy = 3;
					pend = 0;
					mode = 0;
				end
				default: ;
				endcase
				last_cmd = io_bus[7:0];
				acnt = 0;
			end else if (ale) begin
				if (acnt == 0)
					ptr = base + {2'b00, io_bus[7:0]};
				if (acnt == 2 && last_cmd inside {8'h00, 8'h01, 8'h50})
					busy = BUSY_CYC;
				acnt = acnt + 1;
			end else begin
				pbuf[ptr] = io_bus[7:0];
				ptr = ptr + 1;
			end
		end
		if (!ce_n && !output_strobe_n && ostb_q) begin
			case (mode)
			2'd1: dq <= {wp_n, busy == 0, 5'h00, fail_q};
			2'd2: dq <= id_dev ? DEVICE_ID : MAKER_ID;
			default: dq <= mem[ptr];
			endcase
			id_dev = 1;
			if (mode == 0 && ptr < 527)
				ptr = ptr + 1;
		end
		rb_low <= busy != 0;
	end
endmodule
`default_nettype wire

// file: test/nand_host_test.sv
// self-checking bench for the nand flash host controller
// assumes the behavioural flash model; ready line pulled up, model only pulls low
`timescale 1ns/100ps
`default_nettype none
module nand_host_test
	import nand_host_pkg::*;
;
	localparam logic [7:0] MAKER  = 8'h3c; // arbitrary value
	localparam logic [7:0] DEVICE = 8'hc3; // arbitrary value
	logic              sys_clk, srst, psel, penable, pwrite, rb_low;
	logic              pready, pslverr, ce_n, cle, ale, we_n, output_strobe_n, wp_n, io_oe;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, got;
	logic [15:0]       io_out, model_io;
	wire  logic [15:0] io_bus = io_oe ? io_out : model_io;
	wire  logic        rb_n = !rb_low;
	logic [31:0]       q_exp[$], q_mask[$];
	logic              q_err[$];
	logic [7:0]        d [0:3];
	int                err_total, num_checks, cyc;
	nand_host #(.POWERUP_CYCLES(20)) DUT (.sys_clk(sys_clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
		.output_strobe_n(output_strobe_n), .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe),
		.io_in(io_bus), .rb_n(rb_n));
	nand_flash_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) flash (.sys_clk(sys_clk),
		.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .output_strobe_n(output_strobe_n),
		.wp_n(wp_n),
		.io_bus(io_bus), .io_drive(model_io), .rb_low(rb_low));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		// let the watcher take the last read before judging
		repeat (2) @(posedge sys_clk);
		if (q_exp.size() != 0)
			err_total++;
		if (err_total == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [7:0] pat(input int i);
		return i[7:0] ^ 8'h5a;
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		got = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic er);
		q_exp.push_back(e & m);
		q_mask.push_back(m);
		q_err.push_back(er);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd);
	endtask
	// polls active low; gives up after 100 status reads and moves on without flagging an error
	task automatic op(input logic [2:0] o, input logic [7:0] c);
		wr(OFS_CTRL, {16'h0, c, 5'h0, o});
		for (int i = 0; i < 100; i++) begin
			rd(OFS_STATUS, 32'h0, 32'h0, 1'b0);
			if (got[ST_ACTIVE] === 1'b0)
				break;
		end
	endtask
	task automatic rdb(input logic [7:0] e);
		op(OP_RDATA, 8'h00);
		rd(OFS_RDATA, {24'h0, e}, 32'hffff, 1'b0);
	endtask
	task automatic cmd_addr(input logic [7:0] c, input logic [7:0] col);
		op(OP_CMD, c);
		op(OP_ADDR, col);
		op(OP_ADDR, 8'h00);
		op(OP_ADDR, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && q_exp.size() > 0) begin
			check("prdata", q_exp.pop_front(), prdata & q_mask.pop_front());
			check("pslverr", {31'h0, q_err.pop_front()}, {31'h0, pslverr});
		end
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 60000) begin
			err_total++;
			finish_test();
		end
	end
	initial begin
		{srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{err_total, num_checks, cyc} = '0;
		void'($urandom(99));
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		wr(OFS_CTRL, {16'h0, CMD_RESET, 8'h0});
		check("ce_n wp_n", 32'h2, {30'h0, ce_n, wp_n});
		rd(OFS_STATUS, 32'h4, 32'h14, 1'b0);
		wr(OFS_STATUS, 32'h4);
		repeat (25) @(posedge sys_clk);
		wr(OFS_CONFIG, 32'h3);
		rd(OFS_CONFIG, 32'h3, 32'hffffffff, 1'b0);
		rd(8'h20, 32'h0, 32'h0, 1'b1);
		rd(OFS_STATUS, 32'h10, 32'h14, 1'b0);
		op(OP_CMD, CMD_ID);
		op(OP_ADDR, 8'h00);
		rdb(MAKER);
		rdb(DEVICE);
		cmd_addr(CMD_PROG_SET, 8'h00);
		for (int i = 0; i < 4; i++) begin
			d[i] = 8'($urandom);
			wr(OFS_WDATA, {24'h0, d[i]});
			op(OP_WDATA, 8'h00);
		end
		op(OP_CMD, CMD_PROG_GO);
		op(OP_WAIT, 8'h00);
		op(OP_CMD, CMD_STATUS);
		rdb(8'hc0);
		rdb(8'hc0);
		rd(OFS_STATUS, 32'hc022, 32'hff22, 1'b0);
		wr(OFS_CONFIG, 32'h7);
		rdb(8'hc0);
		wr(OFS_CONFIG, 32'h3);
		cmd_addr(CMD_READ_A, 8'h00);
		op(OP_WAIT, 8'h00);
		for (int i = 0; i < 4; i++)
			rdb(pat(i) & d[i]);
		cmd_addr(CMD_READ_C, 8'd14);
		op(OP_WAIT, 8'h00);
		rdb(pat(526));
		rdb(pat(527));
		rdb(pat(527));
		cmd_addr(CMD_READ_B, 8'd5);
		op(OP_WAIT, 8'h00);
		rdb(pat(261));
		op(OP_CMD, CMD_PROG_SET);
		wr(OFS_CTRL, {16'h0, CMD_READ_A, 8'h0});
		rd(OFS_STATUS, 32'h4, 32'h4, 1'b0);
		wr(OFS_STATUS, 32'h4);
		op(OP_CMD, CMD_RESET);
		wr(OFS_CTRL, {16'h0, 8'h33, 8'h0});
		rd(OFS_STATUS, 32'h4, 32'h4, 1'b0);
		wr(OFS_STATUS, 32'h4);
		for (int k = 0; k < 3; k++) begin
			// pass 0: reset aborts erase; pass 1: write guard blocks it; pass 2: erase runs
			wr(OFS_CONFIG, (k == 1) ? 32'h2 : 32'h3);
			cmd_addr(CMD_ERASE, 8'h00);
			op(OP_CMD, CMD_ERASE_GO);
			if (k == 0) begin
				op(OP_CMD, CMD_RESET);
			end else if (k == 2) begin
				// a read order while the erase runs must be turned away
				wr(OFS_CTRL, {16'h0, CMD_READ_A, 8'h0});
				rd(OFS_STATUS, 32'h4, 32'h6, 1'b0);
				wr(OFS_STATUS, 32'h4);
			end
			op(OP_WAIT, 8'h00);
			op(OP_CMD, CMD_STATUS);
			rdb((k == 2) ? 8'hc0 : (k == 1) ? 8'h41 : 8'hc1);
			rd(OFS_STATUS, (k == 2) ? 32'h0 : 32'h8, 32'h8, 1'b0);
			wr(OFS_CONFIG, 32'h3);
			cmd_addr(CMD_READ_A, 8'h00);
			op(OP_WAIT, 8'h00);
			rdb((k == 2) ? 8'hff : pat(0) & d[0]);
		end
		finish_test();
	end
endmodule
`default_nettype wire
